// >>> verilog/vipu_regs.vh
`ifndef VIPU_REGS_VH
`define VIPU_REGS_VH

// ========================================================
// register byte addresses
`define VIPU_ADDR_NORMAL_STATUS   32'hffff0000
`define VIPU_ADDR_NORMAL_RAW      32'hffff0004
`define VIPU_ADDR_NORMAL_ENABLE   32'hffff0008
`define VIPU_ADDR_NORMAL_CLEAR    32'hffff000c
`define VIPU_ADDR_SOFT_CONFIG     32'hffff0010
`define VIPU_ADDR_VECTOR_BASE     32'hffff0014
`define VIPU_ADDR_NORMAL_VECTOR   32'hffff001c
`define VIPU_ADDR_PRIO_TIMERS     32'hffff0020
`define VIPU_ADDR_PRIO_PERIPH_A   32'hffff0024
`define VIPU_ADDR_NEST_CONTROL    32'hffff0030
`define VIPU_ADDR_NORMAL_NEST     32'hffff003c
`define VIPU_ADDR_FAST_STATUS     32'hffff0100
`define VIPU_ADDR_FAST_RAW        32'hffff0104
`define VIPU_ADDR_FAST_ENABLE     32'hffff0108
`define VIPU_ADDR_FAST_CLEAR      32'hffff010c
`define VIPU_ADDR_FAST_VECTOR     32'hffff011c
`define VIPU_ADDR_FAST_NEST       32'hffff013c

// ========================================================
// field positions and widths
`define VIPU_SOFT_NORMAL_BIT      1
`define VIPU_SOFT_FAST_BIT        2
`define VIPU_SOFT_SOURCE          1
`define VIPU_FAST_OR_SOURCE       0
`define VIPU_CTRL_NORMAL_BIT      0
`define VIPU_CTRL_FAST_BIT        1
`define VIPU_NUM_SOURCES          28
`define VIPU_BASE_WIDTH           16
`define VIPU_NEST_LEVELS          8
`define VIPU_PRIO_TIMERS_MASK     32'h07777770
`define VIPU_PRIO_PERIPH_A_MASK   32'h77777007
`define VIPU_RESET_VALUE          32'h00000000

`endif

// >>> verilog/vipu_core.v
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "vipu_regs.vh"

// Functional notes
// [R1] soft config bit 2 drives bit 1 of fast raw and fast status
// [R2] soft config bit 1 drives bit 1 of normal raw and normal status
// [R3] soft interrupt ignores enable masks and drives its interrupt line two clocks after the write
// [R4] sources must hold requests at least the minimum interrupt latency
// [R5] control bit 0 turns on vectoring and priority for normal path
// [R6] control bit 1 turns on vectoring and priority for fast path independently
// [R7] each path nests up to eight priority levels by programmed priorities
// [R8] fast interrupts always outrank normal ones, sixteen levels in total
// [R9] vector is table base combined with active source number
// [R10] vector base points at a table of 32 routine pointers
// [R11] vector base holds 16 writable bits, upper half reads zero
// [R12] vector reads zero, base at 22:7, source at 6:2, zero at 1:0
// [R13] reported source number equals its status bit position
// [R14] software reads normal vector only inside a vectored normal interrupt
// [R15] first priority register: soft 6:4, timers 10:8 to 26:24
// [R16] source 0 has no priority, first priority bits 3:0 reserved
// [R17] second priority register: monitor, flash, converter, serial, i2c fields
// [R18] status is raw AND enable, any status bit requests the exception
// [R19] vector read sets nesting bit of active priority, blocking that and lower
// [R20] equal priorities resolve to the lowest source position
module vipu_core
#(
    parameter NUM_SOURCES = `VIPU_NUM_SOURCES
)
(
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire [31:0] regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata,
    input  wire [27:0] srcReq,
    output reg         irqOut,
    output reg         fiqOut
);

    // ========================================================
    // helper functions
    function [2:0] prioOf;
        input [31:0] p0;
        input [31:0] p1;
        input [4:0]  idx;
        begin
            case (idx)
                5'h01:   prioOf = p0[6:4];                   // R15
                5'h02:   prioOf = p0[10:8];
                5'h03:   prioOf = p0[14:12];
                5'h04:   prioOf = p0[18:16];
                5'h05:   prioOf = p0[22:20];
                5'h06:   prioOf = p0[26:24];
                5'h08:   prioOf = p1[2:0];                   // R17
                5'h0a:   prioOf = p1[10:8];
                5'h0b:   prioOf = p1[14:12];
                5'h0c:   prioOf = p1[18:16];
                5'h0d:   prioOf = p1[22:20];
                5'h0e:   prioOf = p1[26:24];
                5'h0f:   prioOf = p1[30:28];
                default: prioOf = 3'h0;
            endcase
        end
    endfunction

    // returns {found, priority, source}
    function [8:0] pickSrc;
        input [27:0] act;
        input [7:0]  nest;
        input [31:0] p0;
        input [31:0] p1;
        integer      i;
        integer      j;
        reg   [3:0]  lim;
        reg   [2:0]  pr;
        reg   [2:0]  best;
        reg   [4:0]  src;
        reg          found;
        begin
            lim   = 4'h8;
            best  = 3'h0;
            src   = 5'h00;
            found = 1'b0;
            for (j = 7; j >= 0; j = j - 1)
                if (nest[j])
                    lim = j[3:0];                            // R19
            // source 0 is the fast summary and never vectors
            for (i = NUM_SOURCES - 1; i >= 1; i = i - 1)     // R16
            begin
                pr = prioOf(p0, p1, i[4:0]);
                if (act[i] && ({1'b0, pr} < lim) && (!found || pr <= best)) // R20
                begin
                    found = 1'b1;
                    best  = pr;
                    src   = i[4:0];                          // R13
                end
            end
            pickSrc = {found, best, src};
        end
    endfunction

    // clears only the highest-priority set bit, if written with one
    function [7:0] nestClear;
        input [7:0]  nest;
        input [7:0]  wd;
        integer      j;
        reg   [7:0]  res;
        reg          done;
        begin
            res  = nest;
            done = 1'b0;
            for (j = 0; j < 8; j = j + 1)
                if (!done && nest[j])
                begin
                    done = 1'b1;
                    if (wd[j])
                        res[j] = 1'b0;
                end
            nestClear = res;
        end
    endfunction

    // marks a taken priority level as in service
    function [7:0] nestTake;
        input [7:0]  nest;
        input [2:0]  level;
        reg   [7:0]  res;
        begin
            res        = nest;
            res[level] = 1'b1;
            nestTake   = res;
        end
    endfunction

    // vector word: zeros, base at 22:7, source at 6:2, zeros at 1:0
    function [31:0] vecWord;
        input [15:0] base;
        input [4:0]  src;
        begin
            vecWord = {9'h000, base, src, 2'h0};             // R9 R10 R12
        end
    endfunction

    // source maps read back with their top nibble zero
    function [31:0] mapWord;
        input [27:0] map;
        begin
            mapWord = {4'h0, map};
        end
    endfunction

    // ========================================================
    // registers
    reg  [31:0] softCfg;
    reg  [15:0] vectorBase;
    reg  [31:0] prioTimers;
    reg  [31:0] prioPeriphA;
    reg  [1:0]  nestControl;
    reg  [7:0]  normalNest;
    reg  [7:0]  fastNest;
    reg  [27:0] normalEnable;
    reg  [27:0] fastEnable;

    // ========================================================
    // raw, status and selection
    wire [27:0] fastRawBase;
    wire [27:0] fastStatusPre;
    wire        fastAny;
    wire [27:0] normalRaw;
    wire [27:0] fastRaw;
    wire [27:0] normalStatus;
    wire [27:0] fastStatus;
    wire [8:0]  normalPick;
    wire [8:0]  fastPick;
    wire [31:0] normalVector;
    wire [31:0] fastVector;
    wire        ctrlNormal;
    wire        ctrlFast;
    wire        normalTake;
    wire        fastTake;

    assign fastRawBase   = {srcReq[27:2], softCfg[`VIPU_SOFT_FAST_BIT], 1'b0};       // R1
    assign fastStatusPre = fastRawBase & {fastEnable[27:2], 1'b1, 1'b0};             // R3
    assign fastAny       = |fastStatusPre[27:1];
    assign fastRaw       = {fastRawBase[27:1], fastAny};
    assign fastStatus    = {fastStatusPre[27:1], fastAny & fastEnable[0]};           // R18
    assign normalRaw     = {srcReq[27:2], softCfg[`VIPU_SOFT_NORMAL_BIT], fastAny};  // R2
    assign normalStatus  = normalRaw & {normalEnable[27:2], 1'b1, normalEnable[0]};  // R3 R18

    assign ctrlNormal    = nestControl[`VIPU_CTRL_NORMAL_BIT];                       // R5
    assign ctrlFast      = nestControl[`VIPU_CTRL_FAST_BIT];                         // R6
    assign normalPick    = pickSrc(normalStatus, normalNest, prioTimers, prioPeriphA); // R7
    assign fastPick      = pickSrc(fastStatus, fastNest, prioTimers, prioPeriphA);
    assign normalVector  = vecWord(vectorBase, normalPick[4:0]);                     // R9 R10 R12
    assign fastVector    = vecWord(vectorBase, fastPick[4:0]);
    assign normalTake    = regRd && ctrlNormal && normalPick[8] && (regAddr == `VIPU_ADDR_NORMAL_VECTOR);
    assign fastTake      = regRd && ctrlFast && fastPick[8] && (regAddr == `VIPU_ADDR_FAST_VECTOR);

    // ========================================================
    // register writes and nesting
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            softCfg      <= `VIPU_RESET_VALUE;
            vectorBase   <= 16'h0000;
            prioTimers   <= `VIPU_RESET_VALUE;
            prioPeriphA  <= `VIPU_RESET_VALUE;
            nestControl  <= 2'h0;
            normalNest   <= 8'h00;
            fastNest     <= 8'h00;
            normalEnable <= 28'h0000000;
            fastEnable   <= 28'h0000000;
        end
        else
        begin
            if (regWr)
            begin
                case (regAddr)
                    `VIPU_ADDR_SOFT_CONFIG:
                        softCfg <= regWdata & 32'h00000006;                          // R1 R2
                    `VIPU_ADDR_VECTOR_BASE:
                        vectorBase <= regWdata[15:0];                                // R11
                    `VIPU_ADDR_PRIO_TIMERS:
                        prioTimers <= regWdata & `VIPU_PRIO_TIMERS_MASK;             // R15 R16
                    `VIPU_ADDR_PRIO_PERIPH_A:
                        prioPeriphA <= regWdata & `VIPU_PRIO_PERIPH_A_MASK;          // R17
                    `VIPU_ADDR_NEST_CONTROL:
                        nestControl <= regWdata[1:0];
                    `VIPU_ADDR_NORMAL_NEST:
                        normalNest <= nestClear(normalNest, regWdata[7:0]);
                    `VIPU_ADDR_FAST_NEST:
                        fastNest <= nestClear(fastNest, regWdata[7:0]);
                    `VIPU_ADDR_NORMAL_ENABLE:
                    begin
                        normalEnable <= normalEnable | regWdata[27:0];
                        fastEnable   <= fastEnable & ~regWdata[27:0];
                    end
                    `VIPU_ADDR_NORMAL_CLEAR:
                        normalEnable <= normalEnable & ~regWdata[27:0];
                    `VIPU_ADDR_FAST_ENABLE:
                    begin
                        fastEnable   <= fastEnable | regWdata[27:0];
                        normalEnable <= normalEnable & ~regWdata[27:0];
                    end
                    `VIPU_ADDR_FAST_CLEAR:
                        fastEnable <= fastEnable & ~regWdata[27:0];
                    default:
                        softCfg <= softCfg;
                endcase
            end
            // taking the vector locks out its level and all lower ones
            if (normalTake)
                normalNest <= nestTake(normalNest, normalPick[7:5]);                 // R19
            if (fastTake)
                fastNest <= nestTake(fastNest, fastPick[7:5]);                       // R7
        end
    end

    // ========================================================
    // read data and interrupt lines
    always @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            regRdata <= `VIPU_RESET_VALUE;
            irqOut   <= 1'b0;
            fiqOut   <= 1'b0;
        end
        else
        begin
            // core takes the fast line first; it is never gated by normal nesting
            fiqOut <= ctrlFast ? fastPick[8] : (|fastStatus);                        // R8 R6
            irqOut <= ctrlNormal ? normalPick[8] : (|normalStatus);                  // R5 R18
            if (regRd)
            begin
                case (regAddr)
                    `VIPU_ADDR_NORMAL_STATUS:  regRdata <= mapWord(normalStatus);
                    `VIPU_ADDR_NORMAL_RAW:     regRdata <= mapWord(normalRaw);
                    `VIPU_ADDR_NORMAL_ENABLE:  regRdata <= mapWord(normalEnable);
                    `VIPU_ADDR_SOFT_CONFIG:    regRdata <= softCfg;
                    `VIPU_ADDR_VECTOR_BASE:    regRdata <= {16'h0000, vectorBase};       // R11
                    `VIPU_ADDR_NORMAL_VECTOR:  regRdata <= normalVector;                 // R12 R14
                    `VIPU_ADDR_PRIO_TIMERS:    regRdata <= prioTimers;
                    `VIPU_ADDR_PRIO_PERIPH_A:  regRdata <= prioPeriphA;
                    `VIPU_ADDR_NEST_CONTROL:   regRdata <= {30'h00000000, nestControl};
                    `VIPU_ADDR_NORMAL_NEST:    regRdata <= {24'h000000, normalNest};
                    `VIPU_ADDR_FAST_STATUS:    regRdata <= mapWord(fastStatus);
                    `VIPU_ADDR_FAST_RAW:       regRdata <= mapWord(fastRaw);
                    `VIPU_ADDR_FAST_ENABLE:    regRdata <= mapWord(fastEnable);
                    `VIPU_ADDR_FAST_VECTOR:    regRdata <= fastVector;
                    `VIPU_ADDR_FAST_NEST:      regRdata <= {24'h000000, fastNest};
                    default:                   regRdata <= `VIPU_RESET_VALUE;
                endcase
            end
            else
                regRdata <= `VIPU_RESET_VALUE;
        end
    end

endmodule // vipu_core
`default_nettype wire

// >>> bench/vipu_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "vipu_regs.vh"
// ====
// port checks
module vipu_core_properties
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        irqOut,
    input wire logic        fiqOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [15:0] base;
    logic [1:0]  ctrl;
    always @(posedge clk_sys)
        if (!rstn)
        begin
            base <= 16'h0000;
            ctrl <= 2'h0;
        end
        else if (regWr && regAddr == `VIPU_ADDR_VECTOR_BASE)
            base <= regWdata[15:0];
        else if (regWr && regAddr == `VIPU_ADDR_NEST_CONTROL)
            ctrl <= regWdata[1:0];
    property p_rdIdle;
        !regRd |=> regRdata == 32'h0;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("idle read data");
    property p_baseRd;
        regRd && regAddr == `VIPU_ADDR_VECTOR_BASE |=> regRdata == {16'h0, base};
    endproperty
    a_baseRd: assert property (p_baseRd) else $error("base readback");
    property p_vecRd;
        regRd && regAddr == `VIPU_ADDR_NORMAL_VECTOR |=> regRdata[31:23] == 9'h0
            && regRdata[22:7] == base && regRdata[6:2] <= 5'h1b && regRdata[1:0] == 2'h0;
    endproperty
    a_vecRd: assert property (p_vecRd) else $error("vector format");
    property p_prioT;
        regRd && regAddr == `VIPU_ADDR_PRIO_TIMERS |=> (regRdata & ~`VIPU_PRIO_TIMERS_MASK) == 32'h0;
    endproperty
    a_prioT: assert property (p_prioT) else $error("timer priority reserved");
    property p_prioP;
        regRd && regAddr == `VIPU_ADDR_PRIO_PERIPH_A |=> (regRdata & ~`VIPU_PRIO_PERIPH_A_MASK) == 32'h0;
    endproperty
    a_prioP: assert property (p_prioP) else $error("periph priority reserved");
    property p_softIrq;
        (regWr && regAddr == `VIPU_ADDR_SOFT_CONFIG && regWdata[1] && !ctrl[0]) ##1 !regWr |-> ##1 irqOut [*2];
    endproperty
    a_softIrq: assert property (p_softIrq) else $error("soft normal line");
    property p_softFiq;
        regWr && regAddr == `VIPU_ADDR_SOFT_CONFIG && regWdata[2] && !ctrl[1] |-> ##2 fiqOut;
    endproperty
    a_softFiq: assert property (p_softFiq) else $error("soft fast line");
    property p_unmapped;
        regRd && regAddr[31:16] != 16'hffff |=> regRdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule // vipu_core_properties
bind vipu_core vipu_core_properties chk_u (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqOut(irqOut),
    .fiqOut(fiqOut));
`default_nettype wire

// >>> bench/vipu_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// peripheral request sources
module vipu_src_model
#(
    parameter HOLD = 4
)
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic [27:0] raiseReq,
    input wire logic        dropReq,
    output logic     [27:0] srcReq
);
    logic [7:0] held;
    always @(posedge clk_sys)
        if (!rstn)
        begin
            srcReq <= 28'h0;
            held <= 8'h0;
        end
        else if (raiseReq != 28'h0)
        begin
            srcReq <= srcReq | (raiseReq & 28'hffffffc);
            held <= 8'h0;
        end
        else if (dropReq && held >= HOLD)
            srcReq <= 28'h0;
        else if (held != 8'hff)
            held <= held + 8'h1;
endmodule // vipu_src_model
`default_nettype wire

// >>> bench/vipu_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "vipu_regs.vh"
// ====
// bench
module vipu_core_tb;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [31:0] regAddr = 32'h0;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [27:0] raiseReq = 28'h0;
    logic        dropReq = 1'b0;
    wire  [31:0] regRdata;
    wire  [27:0] srcReq;
    wire         irqOut;
    wire         fiqOut;
    int          err_count = 0;
    int          checks_done = 0;
    always #50 clk_sys = ~clk_sys;
    vipu_core dut_u (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcReq(srcReq), .irqOut(irqOut),
        .fiqOut(fiqOut));
    vipu_src_model #(.HOLD(4)) src_u (.clk_sys(clk_sys), .rstn(rstn), .raiseReq(raiseReq),
        .dropReq(dropReq), .srcReq(srcReq));
    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        cmp(regRdata, e);
    endtask
    task lines(input logic i, input logic f);
        repeat (3) @(posedge clk_sys);
        #1;
        cmp({30'h0, irqOut, fiqOut}, {30'h0, i, f});
    endtask
    task t_regs;
        rd(`VIPU_ADDR_PRIO_TIMERS, 32'h0);
        rd(`VIPU_ADDR_NORMAL_VECTOR, 32'h0);
        wr(`VIPU_ADDR_VECTOR_BASE, 32'hffffffff);
        rd(`VIPU_ADDR_VECTOR_BASE, 32'h0000ffff);
        rd(`VIPU_ADDR_NORMAL_VECTOR, 32'h007fff80);
        wr(`VIPU_ADDR_PRIO_TIMERS, 32'hffffffff);
        rd(`VIPU_ADDR_PRIO_TIMERS, 32'h07777770);
        wr(`VIPU_ADDR_PRIO_PERIPH_A, 32'hffffffff);
        rd(`VIPU_ADDR_PRIO_PERIPH_A, 32'h77777007);
        wr(`VIPU_ADDR_PRIO_PERIPH_A, 32'h0);
        rd(32'hffff0018, 32'h0);
        $display("t_regs done");
    endtask
    task t_soft;
        wr(`VIPU_ADDR_SOFT_CONFIG, 32'h2);
        lines(1'b1, 1'b0);
        rd(`VIPU_ADDR_NORMAL_RAW, 32'h2);
        rd(`VIPU_ADDR_NORMAL_STATUS, 32'h2);
        wr(`VIPU_ADDR_SOFT_CONFIG, 32'h4);
        lines(1'b0, 1'b1);
        rd(`VIPU_ADDR_FAST_STATUS, 32'h2);
        wr(`VIPU_ADDR_SOFT_CONFIG, 32'h0);
        lines(1'b0, 1'b0);
        $display("t_soft done");
    endtask
    task t_vec;
        wr(`VIPU_ADDR_VECTOR_BASE, 32'h40);
        wr(`VIPU_ADDR_NEST_CONTROL, 32'h1);
        wr(`VIPU_ADDR_PRIO_TIMERS, 32'h00205000);
        wr(`VIPU_ADDR_NORMAL_ENABLE, 32'h28);
        raiseReq <= 28'h28;
        @(posedge clk_sys);
        raiseReq <= 28'h0;
        lines(1'b1, 1'b0);
        rd(`VIPU_ADDR_NORMAL_VECTOR, 32'h2014);
        rd(`VIPU_ADDR_NORMAL_NEST, 32'h4);
        lines(1'b0, 1'b0);
        wr(`VIPU_ADDR_NORMAL_NEST, 32'hff);
        wr(`VIPU_ADDR_PRIO_TIMERS, 32'h00202000);
        lines(1'b1, 1'b0);
        rd(`VIPU_ADDR_NORMAL_VECTOR, 32'h200c);
        wr(`VIPU_ADDR_NORMAL_NEST, 32'hff);
        rd(`VIPU_ADDR_NORMAL_NEST, 32'h0);
        dropReq <= 1'b1;
        repeat (8) @(posedge clk_sys);
        dropReq <= 1'b0;
        lines(1'b0, 1'b0);
        $display("t_vec done");
    endtask
    task t_fast;
        wr(`VIPU_ADDR_FAST_ENABLE, 32'h1008);
        rd(`VIPU_ADDR_NORMAL_ENABLE, 32'h20);
        wr(`VIPU_ADDR_NEST_CONTROL, 32'h3);
        wr(`VIPU_ADDR_PRIO_PERIPH_A, 32'h30000);
        raiseReq <= 28'h1028;
        @(posedge clk_sys);
        raiseReq <= 28'h0;
        lines(1'b1, 1'b1);
        rd(`VIPU_ADDR_NORMAL_VECTOR, 32'h2014);
        lines(1'b0, 1'b1);
        rd(`VIPU_ADDR_FAST_VECTOR, 32'h200c);
        rd(`VIPU_ADDR_FAST_NEST, 32'h4);
        lines(1'b0, 1'b0);
        wr(`VIPU_ADDR_FAST_CLEAR, 32'h8);
        wr(`VIPU_ADDR_FAST_NEST, 32'hff);
        rd(`VIPU_ADDR_FAST_RAW, 32'h1029);
        rd(`VIPU_ADDR_FAST_STATUS, 32'h1000);
        rd(`VIPU_ADDR_FAST_VECTOR, 32'h2030);
        wr(`VIPU_ADDR_FAST_NEST, 32'hff);
        wr(`VIPU_ADDR_NORMAL_NEST, 32'hff);
        wr(`VIPU_ADDR_NORMAL_CLEAR, 32'h20);
        lines(1'b0, 1'b1);
        dropReq <= 1'b1;
        repeat (8) @(posedge clk_sys);
        dropReq <= 1'b0;
        lines(1'b0, 1'b0);
        $display("t_fast done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs;
        t_soft;
        t_vec;
        t_fast;
        report_and_stop;
    end
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        report_and_stop;
    end
endmodule // vipu_core_tb
`default_nettype wire
